//--- common/frsc_defines.svh
// Purpose: constants of the flash reset state control block
// Assumes: included by the package and by every design file
// Notes: opcodes and option bit positions are fixed values of the device
//
// Summary of operation
// - Power-on and hardware resets ignore inputs and float every output.
// - Reset transactions decode in single-line and quad operation alike.
// - Power-on and hardware resets reset status and all volatile registers.
// - Software reset reloads status and configuration but keeps some registers.
// - Power-on and hardware resets restore volatile protection; nonvolatile protection untouched.
// - Every reset aborts embedded program or erase before normal operation.
// - Every reset loads status and configuration from nonvolatile copies, except config three bit zero, which clears.
// - Learning pattern and boot registers reload on hardware resets, kept on software.
// - Error-correction status and integrity check registers clear on every reset.
// - Hardware resets set persistent lock from two protection option bits.
// - Hardware resets set dynamic protection from one protection option bit.
// - Hardware resets load password as two protection option bits select.
// - Software reset leaves lock, dynamic protection and password unchanged.
// - Soft reset acts only when directly preceded by reset enable.
// - Any other transaction after reset enable cancels the pending enable.
// - Legacy soft reset works only while volatile config three bit zero set.
// - Four clockless chip-select pulses with alternating data zero reset.
`ifndef FRSC_DEFINES_SVH
`define FRSC_DEFINES_SVH

`define FRSC_OP_RESET_ENABLE 8'h66
`define FRSC_OP_SOFT_RESET 8'h99
`define FRSC_OP_LEGACY_RESET 8'hF0
`define FRSC_EDGES_SINGLE 4'h8
`define FRSC_EDGES_QUAD 4'h2
`define FRSC_SIG_PULSES 3'h4
`define FRSC_CFG3_LEGACY_BIT 0
`define FRSC_OPT_DYN_BIT 4
`define FRSC_OPT_LOCK_HI_BIT 2
`define FRSC_OPT_LOCK_LO_BIT 1
`define FRSC_OPT_PWD_SEL_BIT 2
`define FRSC_OPT_PWD_LOAD_BIT 0
`define FRSC_ZERO_BYTE 8'h00
`define FRSC_ONES_BYTE 8'hFF
`define FRSC_PWD_BLANK 64'hFFFF_FFFF_FFFF_FFFF
`define FRSC_STEP_STATUS 4'h0
`define FRSC_STEP_CONFIG 4'h1
`define FRSC_STEP_CFG3 4'h2
`define FRSC_STEP_ECC 4'h3
`define FRSC_STEP_LEARN 4'h4
`define FRSC_STEP_BOOT 4'h5
`define FRSC_STEP_INTEGRITY 4'h6
`define FRSC_STEP_LOCK 4'h7
`define FRSC_STEP_DYN 4'h8
`define FRSC_STEP_PASSWORD 4'h9
`define FRSC_STEP_LAST 4'h9

`endif

//--- common/frsc_pkg.sv
// Purpose: types and reload decode of the flash reset state control block
// Assumes: frsc_defines.svh on the include path
// Notes: none
`include "frsc_defines.svh"

package frsc_pkg;

    typedef enum logic [1:0] {SRC_POWER_ON, SRC_HARDWARE, SRC_SOFTWARE} frsc_source_type;
    typedef enum logic [1:0] {ST_IDLE, ST_ABORT, ST_LOAD} frsc_state_type;
    typedef enum logic [1:0] {ACT_KEEP, ACT_NV, ACT_ZERO, ACT_OPTIONS} frsc_action_type;

    // Per-register reload action for a reset source
    function automatic frsc_action_type frsc_action(input frsc_source_type src, input logic [3:0] step);
        frsc_action_type act;
        act = ACT_KEEP;
        case (step)
            `FRSC_STEP_STATUS, `FRSC_STEP_CONFIG, `FRSC_STEP_CFG3: act = ACT_NV;
            `FRSC_STEP_ECC, `FRSC_STEP_INTEGRITY: act = ACT_ZERO;
            `FRSC_STEP_LEARN, `FRSC_STEP_BOOT: act = (src == SRC_SOFTWARE) ? ACT_KEEP : ACT_NV;
            `FRSC_STEP_LOCK, `FRSC_STEP_DYN, `FRSC_STEP_PASSWORD: act = (src == SRC_SOFTWARE) ? ACT_KEEP : ACT_OPTIONS;
            default: act = ACT_KEEP;
        endcase
        return act;
    endfunction

endpackage

//--- logic/frsc_link_decode.sv
// Purpose: opcode capture on the serial clock
// Assumes: chip select high clears the frame's edge count
// Notes: opcode holds until the next frame's last opcode edge
`timescale 1ns/1ps
`include "frsc_defines.svh"

module frsc_link_decode (
    // Link clock and frame
    input wire logic sck,
    input wire logic csN,
    input wire logic rst,
    // Link data and mode
    input wire logic [3:0] dqIn,
    input wire logic quadMode,
    // Toward the core clock
    output logic [7:0] opcode,
    output logic opToggle,
    output logic actToggle
);

    logic quadSync;
    logic [3:0] edgeCount;
    logic [7:0] shifter;
    logic [7:0] next_shifter;
    logic [3:0] lastEdge;

    // Mode taken as each frame opens; link clock is still between frames
    always_ff @(negedge csN or posedge rst) begin
        if (rst) begin
            quadSync <= 1'b0;
        end else begin
            quadSync <= quadMode;
        end
    end

    // Quad shifts a nibble per edge, single one bit
    assign lastEdge = quadSync ? `FRSC_EDGES_QUAD : `FRSC_EDGES_SINGLE;
    assign next_shifter = quadSync ? {shifter[3:0], dqIn} : {shifter[6:0], dqIn[0]};

    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            edgeCount <= 4'h0;
            shifter <= `FRSC_ZERO_BYTE;
        end else begin
            shifter <= next_shifter;
            if (edgeCount != 4'hF) begin
                edgeCount <= edgeCount + 4'h1;
            end
        end
    end

    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            opcode <= `FRSC_ZERO_BYTE;
            opToggle <= 1'b0;
            actToggle <= 1'b0;
        end else if (!csN) begin
            if (edgeCount == 4'h0) begin
                actToggle <= ~actToggle;
            end
            if (edgeCount + 4'h1 == lastEdge) begin
                opcode <= next_shifter;
                opToggle <= ~opToggle;
            end
        end
    end

endmodule // frsc_link_decode

//--- logic/frsc_reset_control.sv
// Purpose: decides what each reset source does to registers and operations
// Assumes: rst is the power-on reset; nonvolatile copies are stable inputs
// Notes: link pins cross by two flip-flops; opcode by toggle handshake
`timescale 1ns/1ps
`include "frsc_defines.svh"

module frsc_reset_control (
    // Clocks and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    // Link pins
    input wire logic csN,
    input wire logic [3:0] dqIn,
    input wire logic [3:0] coreDqOut,
    input wire logic [3:0] coreDqOe,
    output logic [3:0] dqOut,
    output logic [3:0] dqOe,
    // Hardware reset pin
    input wire logic hwResetN,
    // Device core
    input wire logic quadMode,
    input wire logic opsBusy,
    input wire logic cfg3WriteEn,
    input wire logic [7:0] cfg3WriteData,
    output logic abortOps,
    output logic resetBusy,
    output logic interfaceQuiet,
    output frsc_pkg::frsc_source_type resetSource,
    // Nonvolatile copies
    input wire logic [7:0] nvStatus,
    input wire logic [7:0] nvConfig,
    input wire logic [7:0] nvCfg3,
    input wire logic [7:0] nvDataLearning,
    input wire logic [7:0] nvBoot,
    input wire logic [63:0] nvPassword,
    input wire logic [7:0] advancedProtectionOptions,
    // Volatile registers
    output logic [7:0] statusReg,
    output logic [7:0] configReg,
    output logic [7:0] configReg3Volatile,
    output logic [7:0] eccStatus,
    output logic [7:0] dataLearning,
    output logic [7:0] bootReg,
    output logic [7:0] dataIntegrity,
    output logic persistentSectorProtectLock,
    output logic [7:0] dynamicSectorProtect,
    output logic [63:0] passwordReg
);

    ////////////////////////////////////////////////////////////////////////
    // Pin and toggle synchronisers

    logic [7:0] opcode;
    logic opToggle;
    logic actToggle;
    logic [4:0] syncMeta;
    logic [4:0] syncStage;
    logic [2:0] syncLast;
    logic csSync;
    logic dq0Sync;
    logic hwSync;

    frsc_link_decode linkDecode (
        .sck(sck),
        .csN(csN),
        .rst(rst),
        .dqIn(dqIn),
        .quadMode(quadMode),
        .opcode(opcode),
        .opToggle(opToggle),
        .actToggle(actToggle)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Idle levels: pin and select high, toggles low
            syncMeta <= 5'h18;
            syncStage <= 5'h18;
            syncLast <= 3'h4;
        end else begin
            syncMeta <= {hwResetN, csN, dqIn[0], opToggle, actToggle};
            syncStage <= syncMeta;
            syncLast <= {syncStage[3], syncStage[1:0]};
        end
    end

    assign hwSync = syncStage[4];
    assign csSync = syncStage[3];
    assign dq0Sync = syncStage[2];

    logic opEvent;
    logic actEvent;
    logic frameEnd;

    assign opEvent = syncStage[1] ^ syncLast[1];
    assign actEvent = syncStage[0] ^ syncLast[0];
    assign frameEnd = csSync && !syncLast[2];

    ////////////////////////////////////////////////////////////////////////
    // Transaction decode at frame end

    frsc_pkg::frsc_state_type state;
    frsc_pkg::frsc_source_type source;
    logic [3:0] step;
    logic [7:0] frameOp;
    logic frameHasOp;
    logic frameActive;
    logic resetArmed;
    logic softStart;
    logic legacyStart;
    logic sigStart;
    logic [2:0] sigCount;
    logic idleLink;

    // Opcode frames count only while the interface listens; signal pulses count at any time
    assign idleLink = (state == frsc_pkg::ST_IDLE);
    assign softStart = idleLink && frameEnd && frameHasOp && resetArmed
        && frameOp == `FRSC_OP_SOFT_RESET;
    assign legacyStart = idleLink && frameEnd && frameHasOp && frameOp == `FRSC_OP_LEGACY_RESET
        && configReg3Volatile[`FRSC_CFG3_LEGACY_BIT];
    assign sigStart = frameEnd && !frameActive && dq0Sync == sigCount[0]
        && sigCount == `FRSC_SIG_PULSES - 3'h1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frameOp <= `FRSC_ZERO_BYTE;
            frameHasOp <= 1'b0;
            frameActive <= 1'b0;
        end else if (frameEnd) begin
            frameHasOp <= 1'b0;
            frameActive <= 1'b0;
        end else begin
            if (opEvent) begin
                frameOp <= opcode;
                frameHasOp <= 1'b1;
            end
            if (actEvent) begin
                frameActive <= 1'b1;
            end
        end
    end

    // Any clocked frame other than reset enable drops the arm
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resetArmed <= 1'b0;
        end else if (!idleLink) begin
            resetArmed <= 1'b0;
        end else if (frameEnd && frameActive) begin
            resetArmed <= frameHasOp && frameOp == `FRSC_OP_RESET_ENABLE;
        end
    end

    // Clockless pulses, data zero low first then alternating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sigCount <= 3'h0;
        end else if (frameEnd) begin
            if (frameActive || sigStart) begin
                sigCount <= 3'h0;
            end else if (dq0Sync == sigCount[0]) begin
                sigCount <= sigCount + 3'h1;
            end else begin
                sigCount <= dq0Sync ? 3'h0 : 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reload sequencer

    logic hwStart;
    frsc_pkg::frsc_action_type curAction;

    assign hwStart = !hwSync || sigStart;
    assign curAction = frsc_pkg::frsc_action(source, step);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= frsc_pkg::ST_ABORT;
            source <= frsc_pkg::SRC_POWER_ON;
            step <= `FRSC_STEP_STATUS;
        end else if (hwStart && source != frsc_pkg::SRC_POWER_ON) begin
            state <= frsc_pkg::ST_ABORT;
            source <= frsc_pkg::SRC_HARDWARE;
            step <= `FRSC_STEP_STATUS;
        end else begin
            unique case (state)
                frsc_pkg::ST_IDLE: begin
                    if (softStart || legacyStart) begin
                        state <= frsc_pkg::ST_ABORT;
                        source <= frsc_pkg::SRC_SOFTWARE;
                    end
                end
                frsc_pkg::ST_ABORT: begin
                    step <= `FRSC_STEP_STATUS;
                    if (!opsBusy && hwSync) begin
                        state <= frsc_pkg::ST_LOAD;
                    end
                end
                frsc_pkg::ST_LOAD: begin
                    step <= step + 4'h1;
                    if (step == `FRSC_STEP_LAST) begin
                        state <= frsc_pkg::ST_IDLE;
                        source <= frsc_pkg::SRC_HARDWARE;
                    end
                end
            endcase
        end
    end

    assign abortOps = (state == frsc_pkg::ST_ABORT);
    assign resetBusy = (state != frsc_pkg::ST_IDLE);
    assign interfaceQuiet = resetBusy && source != frsc_pkg::SRC_SOFTWARE;
    assign resetSource = source;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dqOut <= 4'h0;
            dqOe <= 4'h0;
        end else begin
            dqOut <= interfaceQuiet ? 4'h0 : coreDqOut;
            dqOe <= interfaceQuiet ? 4'h0 : coreDqOe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Volatile register reload

    logic loading;
    logic [7:0] opts;

    assign loading = (state == frsc_pkg::ST_LOAD);
    assign opts = advancedProtectionOptions;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            statusReg <= `FRSC_ZERO_BYTE;
            configReg <= `FRSC_ZERO_BYTE;
            configReg3Volatile <= `FRSC_ZERO_BYTE;
            eccStatus <= `FRSC_ZERO_BYTE;
            dataLearning <= `FRSC_ZERO_BYTE;
            bootReg <= `FRSC_ZERO_BYTE;
            dataIntegrity <= `FRSC_ZERO_BYTE;
            persistentSectorProtectLock <= 1'b0;
            dynamicSectorProtect <= `FRSC_ONES_BYTE;
            passwordReg <= `FRSC_PWD_BLANK;
        end else if (loading && curAction != frsc_pkg::ACT_KEEP) begin
            unique case (step)
                `FRSC_STEP_STATUS: statusReg <= nvStatus;
                `FRSC_STEP_CONFIG: configReg <= nvConfig;
                `FRSC_STEP_CFG3: configReg3Volatile <= nvCfg3 & ~8'h01;
                `FRSC_STEP_ECC: eccStatus <= `FRSC_ZERO_BYTE;
                `FRSC_STEP_LEARN: dataLearning <= nvDataLearning;
                `FRSC_STEP_BOOT: bootReg <= nvBoot;
                `FRSC_STEP_INTEGRITY: dataIntegrity <= `FRSC_ZERO_BYTE;
                `FRSC_STEP_LOCK: persistentSectorProtectLock <= opts[`FRSC_OPT_LOCK_HI_BIT]
                    & opts[`FRSC_OPT_LOCK_LO_BIT];
                `FRSC_STEP_DYN: dynamicSectorProtect <= opts[`FRSC_OPT_DYN_BIT] ? `FRSC_ZERO_BYTE
                    : `FRSC_ONES_BYTE;
                `FRSC_STEP_PASSWORD: passwordReg <= (!opts[`FRSC_OPT_PWD_SEL_BIT]
                    || !opts[`FRSC_OPT_PWD_LOAD_BIT]) ? nvPassword : `FRSC_PWD_BLANK;
                default: statusReg <= statusReg;
            endcase
        end else if (cfg3WriteEn && idleLink) begin
            configReg3Volatile <= cfg3WriteData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_quiet_drive_off: assert property (@(posedge clock) disable iff (rst)
        interfaceQuiet |=> dqOe == 4'h0) else $error("outputs driven during reset");
    a_soft_needs_arm: assert property (@(posedge clock) disable iff (rst)
        idleLink && frameEnd && frameOp == `FRSC_OP_SOFT_RESET && !resetArmed && hwSync && !sigStart
        && !legacyStart |=> state == frsc_pkg::ST_IDLE) else $error("soft reset without enable");
    a_hw_pin_start: assert property (@(posedge clock) disable iff (rst)
        $fell(hwSync) && source != frsc_pkg::SRC_POWER_ON |=> abortOps && source == frsc_pkg::SRC_HARDWARE)
        else $error("hardware reset not started");
    a_abort_hold: assert property (@(posedge clock) disable iff (rst)
        abortOps && opsBusy |=> abortOps) else $error("left abort while busy");
    a_ecc_cleared: assert property (@(posedge clock) disable iff (rst)
        loading && step == `FRSC_STEP_ECC ##1 !loading || step == `FRSC_STEP_LEARN |-> eccStatus == 8'h00)
        else $error("ecc status not cleared");
    a_lock_kept_soft: assert property (@(posedge clock) disable iff (rst)
        loading && source == frsc_pkg::SRC_SOFTWARE && hwSync && !sigStart |=> $stable(passwordReg)
        && $stable(persistentSectorProtectLock) && $stable(dynamicSectorProtect))
        else $error("protection changed by soft reset");
    a_learn_kept_soft: assert property (@(posedge clock) disable iff (rst)
        loading && source == frsc_pkg::SRC_SOFTWARE && hwSync && !sigStart |=> $stable(dataLearning)
        && $stable(bootReg)) else $error("learning or boot changed by soft reset");
    a_load_length: assert property (@(posedge clock) disable iff (rst)
        $rose(loading) && source == frsc_pkg::SRC_SOFTWARE && hwSync |-> ##9 step == `FRSC_STEP_LAST)
        else $error("reload sequence length wrong");
    a_legacy_gated: assert property (@(posedge clock) disable iff (rst)
        idleLink && frameEnd && !resetArmed && hwSync && !sigStart
        && !configReg3Volatile[`FRSC_CFG3_LEGACY_BIT] |=> state == frsc_pkg::ST_IDLE)
        else $error("legacy reset while disabled");
    a_dyn_options: assert property (@(posedge clock) disable iff (rst)
        loading && step == `FRSC_STEP_DYN && source != frsc_pkg::SRC_SOFTWARE
        |=> dynamicSectorProtect == ($past(opts[`FRSC_OPT_DYN_BIT]) ? 8'h00 : 8'hFF))
        else $error("dynamic protect default wrong");

    c_soft_reset: cover property (@(posedge clock) disable iff (rst) softStart);
    c_legacy_reset: cover property (@(posedge clock) disable iff (rst) legacyStart);
    c_signal_reset: cover property (@(posedge clock) disable iff (rst) sigStart);
    c_pin_reset: cover property (@(posedge clock) disable iff (rst) $fell(hwSync) ##[1:300] loading);

endmodule // frsc_reset_control

//--- tb/frsc_host_model.sv
// Purpose: host controller model that sends reset frames on the link
// Assumes: called at a core clock falling edge; link clock period 125 ns
// Notes: link clock stands still between frames; released data lines invert
`timescale 1ns/1ps

module frsc_host_model (
    // Link clock and frame
    output logic sck,
    output logic csN,
    // Link data
    output logic [3:0] dqIn
);
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        dqIn = 4'h5;
    end

    // One opcode frame, single line or quad, then idle gap
    task automatic send_op(input logic [7:0] code, input logic quad);
        int n;
        n = quad ? 2 : 8;
        csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (quad) begin
                dqIn = (i == 0) ? code[7:4] : code[3:0];
            end else begin
                dqIn = {~dqIn[3:1], code[7 - i]};
            end
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
        dqIn = ~dqIn;
        csN = 1'b1;
        #500;
    endtask

    // Four clockless select pulses, data zero per pattern bit
    task automatic signal_reset(input logic [3:0] pattern);
        for (int i = 0; i < 4; i++) begin
            dqIn[0] = pattern[i];
            csN = 1'b0;
            #250 csN = 1'b1;
            #250;
        end
    endtask
endmodule // frsc_host_model

//--- tb/tb.sv
// Purpose: self-checking bench of the flash reset state control block
// Assumes: link frames come from the host model
// Notes: nonvolatile copies are redrawn before each reset so kept values show
`timescale 1ns/1ps
`include "frsc_defines.svh"

module tb;
    logic clock, rst, sck, csN, hwResetN, quadMode, opsBusy, cfg3WriteEn;
    logic abortOps, resetBusy, interfaceQuiet, persistentSectorProtectLock, eLock;
    logic [3:0] dqIn, coreDqOut, coreDqOe, dqOut, dqOe;
    logic [7:0] cfg3WriteData, nvStatus, nvConfig, nvCfg3, nvDataLearning, nvBoot, advancedProtectionOptions;
    logic [7:0] statusReg, configReg, configReg3Volatile, eccStatus, dataLearning, bootReg, dataIntegrity;
    logic [7:0] dynamicSectorProtect, eLearn, eBoot, eDyn;
    logic [63:0] nvPassword, passwordReg, ePwd;
    frsc_pkg::frsc_source_type resetSource;
    int fail_count = 0;
    int check_count = 0;

    frsc_reset_control frsc_reset_control_i (.clock(clock), .rst(rst), .sck(sck), .csN(csN), .dqIn(dqIn),
        .coreDqOut(coreDqOut), .coreDqOe(coreDqOe), .dqOut(dqOut), .dqOe(dqOe), .hwResetN(hwResetN),
        .quadMode(quadMode), .opsBusy(opsBusy), .cfg3WriteEn(cfg3WriteEn), .cfg3WriteData(cfg3WriteData),
        .abortOps(abortOps), .resetBusy(resetBusy), .interfaceQuiet(interfaceQuiet), .resetSource(resetSource),
        .nvStatus(nvStatus), .nvConfig(nvConfig), .nvCfg3(nvCfg3), .nvDataLearning(nvDataLearning),
        .nvBoot(nvBoot), .nvPassword(nvPassword), .advancedProtectionOptions(advancedProtectionOptions),
        .statusReg(statusReg), .configReg(configReg), .configReg3Volatile(configReg3Volatile),
        .eccStatus(eccStatus), .dataLearning(dataLearning), .bootReg(bootReg), .dataIntegrity(dataIntegrity),
        .persistentSectorProtectLock(persistentSectorProtectLock), .dynamicSectorProtect(dynamicSectorProtect),
        .passwordReg(passwordReg));

    frsc_host_model frsc_host_model_i (.sck(sck), .csN(csN), .dqIn(dqIn));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #1_500_000;
        fail_count++;
        $display("ERROR %0t: watchdog expired", $time);
        results();
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] dyn_exp(input logic [7:0] opt);
        return opt[4] ? 8'h00 : 8'hFF;
    endfunction

    function automatic logic [63:0] pwd_exp(input logic [7:0] opt, input logic [63:0] nv);
        return (!opt[2] || !opt[0]) ? nv : 64'hFFFF_FFFF_FFFF_FFFF;
    endfunction

    ////////////////////////////////////////////////////////////////
    task automatic draw();
        nvStatus = 8'($urandom);
        nvConfig = 8'($urandom);
        nvCfg3 = 8'($urandom);
        nvDataLearning = 8'($urandom);
        nvBoot = 8'($urandom);
        advancedProtectionOptions = 8'($urandom);
        nvPassword = {$urandom, $urandom};
        coreDqOut = 4'($urandom);
    endtask

    task automatic op(input logic [7:0] code);
        frsc_host_model_i.send_op(code, quadMode);
    endtask

    task automatic wait_busy(input logic want);
        int n;
        n = 0;
        while (resetBusy !== want && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk(64'(resetBusy), 64'(want), "busy wait");
    endtask

    task automatic no_reset();
        repeat (12) @(negedge clock);
        chk(64'(resetBusy), 64'h0, "unexpected reset");
    endtask

    // Follows one reset from start to idle, then checks every register
    task automatic run_reset(input frsc_pkg::frsc_source_type src);
        wait_busy(1'b1);
        chk(64'(resetSource), 64'(src), "source");
        chk(64'(interfaceQuiet), 64'(src != frsc_pkg::SRC_SOFTWARE), "quiet");
        repeat (4) @(negedge clock);
        chk(64'(abortOps), 64'h1, "abort held while busy");
        if (src != frsc_pkg::SRC_SOFTWARE) begin
            chk(64'(dqOe), 64'h0, "outputs floated");
            chk(64'(dqOut), 64'h0, "data held low");
        end
        opsBusy = 1'b0;
        hwResetN = 1'b1;
        wait_busy(1'b0);
        opsBusy = 1'b1;
        if (src != frsc_pkg::SRC_SOFTWARE) begin
            eLearn = nvDataLearning;
            eBoot = nvBoot;
            eLock = advancedProtectionOptions[2] & advancedProtectionOptions[1];
            eDyn = dyn_exp(advancedProtectionOptions);
            ePwd = pwd_exp(advancedProtectionOptions, nvPassword);
        end
        chk(64'(statusReg), 64'(nvStatus), "status");
        chk(64'(configReg), 64'(nvConfig), "config");
        chk(64'(configReg3Volatile), 64'(nvCfg3 & 8'hFE), "config three");
        chk(64'(eccStatus), 64'h0, "ecc status");
        chk(64'(dataIntegrity), 64'h0, "integrity");
        chk(64'(dataLearning), 64'(eLearn), "learning");
        chk(64'(bootReg), 64'(eBoot), "boot");
        chk(64'(persistentSectorProtectLock), 64'(eLock), "lock");
        chk(64'(dynamicSectorProtect), 64'(eDyn), "dynamic");
        chk(passwordReg, ePwd, "password");
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] other;
        other = 8'($urandom(32'h2A7A));
        rst = 1'b1;
        hwResetN = 1'b1;
        quadMode = 1'b0;
        opsBusy = 1'b1;
        cfg3WriteEn = 1'b0;
        cfg3WriteData = 8'h00;
        coreDqOe = 4'hF;
        draw();
        repeat (20) @(negedge clock);
        chk(64'(dqOe), 64'h0, "outputs during reset");
        chk(64'(abortOps), 64'h1, "abort during reset");
        rst = 1'b0;
        run_reset(frsc_pkg::SRC_POWER_ON);
        repeat (2) @(negedge clock);
        chk(64'(dqOe), 64'(coreDqOe), "enable when idle");
        chk(64'(dqOut), 64'(coreDqOut), "data when idle");
        for (int r = 0; r < 4; r++) begin
            quadMode = r[0];
            draw();
            op(`FRSC_OP_RESET_ENABLE);
            op(`FRSC_OP_SOFT_RESET);
            run_reset(frsc_pkg::SRC_SOFTWARE);
            op(`FRSC_OP_SOFT_RESET);
            no_reset();
            other = 8'($urandom_range(8'h65, 8'h00));
            op(`FRSC_OP_RESET_ENABLE);
            op(other);
            op(`FRSC_OP_SOFT_RESET);
            no_reset();
            op(`FRSC_OP_LEGACY_RESET);
            no_reset();
            cfg3WriteData = 8'($urandom) | 8'h01;
            cfg3WriteEn = 1'b1;
            @(negedge clock);
            cfg3WriteEn = 1'b0;
            draw();
            op(`FRSC_OP_LEGACY_RESET);
            run_reset(frsc_pkg::SRC_SOFTWARE);
            draw();
            frsc_host_model_i.signal_reset(4'b1110);
            no_reset();
            frsc_host_model_i.signal_reset(4'b1010);
            run_reset(frsc_pkg::SRC_HARDWARE);
            draw();
            hwResetN = 1'b0;
            op(`FRSC_OP_RESET_ENABLE);
            run_reset(frsc_pkg::SRC_HARDWARE);
            op(`FRSC_OP_SOFT_RESET);
            no_reset();
        end
        results();
    end
endmodule // tb
